// File: shared/fault_latch_regs.svh
// Register offsets, field positions and reset values of the input fault latch bank.
// Functional notes
// - Summary bits 7..4 show channels 1..4 latch holds any fault.
// - Summary bit 1 shows a battery short seen while battery below bias.
// - Summary bits 3, 2, 0 are reserved, read zero; software writes only zero.
// - Channel 1 latch captures and holds faults; resets to zero.
// - Channel 1 bit 7 latches an open input detection.
// - Channel 1 bit 6 latches the input pair shorted together.
// - Channel 1 bits 5 and 4 latch positive or negative leg ground shorts.
// - Channel 1 bits 3 and 2 latch leg shorts to microphone bias.
// - Channel 1 bits 1 and 0 latch leg shorts to battery.
// - Negative-leg battery bit clears on reading page 0 address 54, not own read.
// - Channel 2 has its own latch register mirroring channel 1, reset zero.
`ifndef FAULT_LATCH_REGS_SVH
`define FAULT_LATCH_REGS_SVH
`define SUMMARY_ADDR 8'h2D
`define CH1_LATCH_ADDR 8'h2E
`define CH2_LATCH_ADDR 8'h2F
`define GLOBAL_LATCH_THIRD_ADDR 8'h36
`define FAULT_PAGE 8'h00
`define LATCH_RESET 8'h00
`define SUM_CH1_BIT 7
`define SUM_CH2_BIT 6
`define SUM_CH3_BIT 5
`define SUM_CH4_BIT 4
`define SUM_VBAT_LOW_BIT 1
`define FLT_OPEN_BIT 7
`define FLT_PAIR_BIT 6
`define FLT_P_GND_BIT 5
`define FLT_M_GND_BIT 4
`define FLT_P_BIAS_BIT 3
`define FLT_M_BIAS_BIT 2
`define FLT_P_VBAT_BIT 1
`define FLT_M_VBAT_BIT 0
`endif

// File: shared/fault_latch_pkg.sv
// Types shared by the input fault latch bank.
package fault_latch_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef struct packed {
		logic [7:0] ch1_q;
		logic [7:0] ch2_q;
		logic [7:0] ch3_q;
		logic [7:0] ch4_q;
		logic vbat_low_q;
		logic [7:0] rdata_q;
	} bank_state_t;
endpackage

// File: src/channel_fault_latch.sv
// One channel's eight-bit sticky fault latch with read clearing.
`timescale 1ns/1ps
`include "fault_latch_regs.svh"
module channel_fault_latch #(
	parameter int SHARED_CLR_BIT = `FLT_M_VBAT_BIT // Latch bit freed by the third global latch read.
) (
	input wire logic [7:0] i_cur, // Current latch value.
	input wire logic [7:0] i_det, // Fault detections this cycle.
	input wire logic i_own_rd, // Host read of this latch.
	input wire logic i_third_rd, // Host read of the third global latch.
	output logic [7:0] o_next // Next latch value.
);
	logic [7:0] clr;
	always_comb begin
		clr = {8{i_own_rd}};
		clr[SHARED_CLR_BIT] = i_third_rd;
		// A detection in the clearing cycle wins so no fault is lost.
		o_next = (i_cur & ~clr) | i_det;
	end
endmodule

// File: src/input_fault_latch_status.sv
// Latched input fault status registers read by the host control port.
`timescale 1ns/1ps
`include "fault_latch_regs.svh"
module input_fault_latch_status (
	input wire logic i_clk, // 40 MHz clock.
	input wire logic i_rst_b, // Asynchronous reset, active low.
	input wire fault_latch_pkg::reg_byte_t i_page, // Current register page.
	input wire fault_latch_pkg::reg_byte_t i_addr, // Register address.
	input wire logic i_rd, // One-cycle read strobe.
	input wire logic i_wr, // One-cycle write strobe.
	input wire fault_latch_pkg::reg_byte_t i_wdata, // Write data, ignored by these registers.
	input wire fault_latch_pkg::reg_byte_t i_ch1_det, // Channel 1 fault detection pulses.
	input wire fault_latch_pkg::reg_byte_t i_ch2_det, // Channel 2 fault detection pulses.
	input wire fault_latch_pkg::reg_byte_t i_ch3_det, // Channel 3 fault detection pulses.
	input wire fault_latch_pkg::reg_byte_t i_ch4_det, // Channel 4 fault detection pulses.
	input wire logic i_vbat_low_det, // Battery short seen while battery below bias.
	output fault_latch_pkg::reg_byte_t o_rdata // Read data, valid the cycle after i_rd.
);
	import fault_latch_pkg::*;

	bank_state_t s_q;
	bank_state_t s_d;
	logic pg;
	logic rd_sum;
	logic rd_ch1;
	logic rd_ch2;
	logic rd_third;

	// Detection taps of channels 1 and 2, one per fault kind.
	logic ch1_open_det;
	logic ch1_pair_det;
	logic ch1_p_gnd_det;
	logic ch1_m_gnd_det;
	logic ch1_p_bias_det;
	logic ch1_m_bias_det;
	logic ch1_p_vbat_det;
	logic ch1_m_vbat_det;
	reg_byte_t ch1_det_fields;

	logic ch2_open_det;
	logic ch2_pair_det;
	logic ch2_p_gnd_det;
	logic ch2_m_gnd_det;
	logic ch2_p_bias_det;
	logic ch2_m_bias_det;
	logic ch2_p_vbat_det;
	logic ch2_m_vbat_det;
	reg_byte_t ch2_det_fields;

	reg_byte_t ch1_n;
	reg_byte_t ch2_n;
	reg_byte_t ch3_n;
	reg_byte_t ch4_n;

	logic ch1_any;
	logic ch2_any;
	logic ch3_any;
	logic ch4_any;
	reg_byte_t summary;
	reg_byte_t rd_mux;

	// Every register of this bank lives on page zero; the same offsets on other pages belong elsewhere.
	assign pg = (i_page == `FAULT_PAGE);
	assign rd_sum = i_rd && pg && (i_addr == `SUMMARY_ADDR);
	assign rd_ch1 = i_rd && pg && (i_addr == `CH1_LATCH_ADDR);
	assign rd_ch2 = i_rd && pg && (i_addr == `CH2_LATCH_ADDR);
	// The third global latch is not held here, but reading it is what frees each channel's negative-leg battery bit.
	assign rd_third = i_rd && pg && (i_addr == `GLOBAL_LATCH_THIRD_ADDR);

	// Channel 1 detections split by fault kind, so a slip in the bit order shows up by name.
	assign ch1_open_det = i_ch1_det[`FLT_OPEN_BIT];
	assign ch1_pair_det = i_ch1_det[`FLT_PAIR_BIT];
	assign ch1_p_gnd_det = i_ch1_det[`FLT_P_GND_BIT];
	assign ch1_m_gnd_det = i_ch1_det[`FLT_M_GND_BIT];
	assign ch1_p_bias_det = i_ch1_det[`FLT_P_BIAS_BIT];
	assign ch1_m_bias_det = i_ch1_det[`FLT_M_BIAS_BIT];
	assign ch1_p_vbat_det = i_ch1_det[`FLT_P_VBAT_BIT];
	assign ch1_m_vbat_det = i_ch1_det[`FLT_M_VBAT_BIT];

	always_comb begin
		ch1_det_fields = `LATCH_RESET;
		ch1_det_fields[`FLT_OPEN_BIT] = ch1_open_det;
		ch1_det_fields[`FLT_PAIR_BIT] = ch1_pair_det;
		ch1_det_fields[`FLT_P_GND_BIT] = ch1_p_gnd_det;
		ch1_det_fields[`FLT_M_GND_BIT] = ch1_m_gnd_det;
		ch1_det_fields[`FLT_P_BIAS_BIT] = ch1_p_bias_det;
		ch1_det_fields[`FLT_M_BIAS_BIT] = ch1_m_bias_det;
		ch1_det_fields[`FLT_P_VBAT_BIT] = ch1_p_vbat_det;
		ch1_det_fields[`FLT_M_VBAT_BIT] = ch1_m_vbat_det;
	end

	// Channel 2 carries the same eight fault kinds in the same bit order.
	assign ch2_open_det = i_ch2_det[`FLT_OPEN_BIT];
	assign ch2_pair_det = i_ch2_det[`FLT_PAIR_BIT];
	assign ch2_p_gnd_det = i_ch2_det[`FLT_P_GND_BIT];
	assign ch2_m_gnd_det = i_ch2_det[`FLT_M_GND_BIT];
	assign ch2_p_bias_det = i_ch2_det[`FLT_P_BIAS_BIT];
	assign ch2_m_bias_det = i_ch2_det[`FLT_M_BIAS_BIT];
	assign ch2_p_vbat_det = i_ch2_det[`FLT_P_VBAT_BIT];
	assign ch2_m_vbat_det = i_ch2_det[`FLT_M_VBAT_BIT];

	always_comb begin
		ch2_det_fields = `LATCH_RESET;
		ch2_det_fields[`FLT_OPEN_BIT] = ch2_open_det;
		ch2_det_fields[`FLT_PAIR_BIT] = ch2_pair_det;
		ch2_det_fields[`FLT_P_GND_BIT] = ch2_p_gnd_det;
		ch2_det_fields[`FLT_M_GND_BIT] = ch2_m_gnd_det;
		ch2_det_fields[`FLT_P_BIAS_BIT] = ch2_p_bias_det;
		ch2_det_fields[`FLT_M_BIAS_BIT] = ch2_m_bias_det;
		ch2_det_fields[`FLT_P_VBAT_BIT] = ch2_p_vbat_det;
		ch2_det_fields[`FLT_M_VBAT_BIT] = ch2_m_vbat_det;
	end

	// Only the negative-leg battery bit waits for the third global latch read; the rest clear on their own read.
	channel_fault_latch #(
		.SHARED_CLR_BIT(`FLT_M_VBAT_BIT)
	) u_ch1 (
		.i_cur(s_q.ch1_q),
		.i_det(ch1_det_fields),
		.i_own_rd(rd_ch1),
		.i_third_rd(rd_third),
		.o_next(ch1_n)
	);

	channel_fault_latch #(
		.SHARED_CLR_BIT(`FLT_M_VBAT_BIT)
	) u_ch2 (
		.i_cur(s_q.ch2_q),
		.i_det(ch2_det_fields),
		.i_own_rd(rd_ch2),
		.i_third_rd(rd_third),
		.o_next(ch2_n)
	);

	// Channels 3 and 4 have no host view here; only their negative-leg battery bit clears, on the third global latch read, and the rest never clear.
	channel_fault_latch #(
		.SHARED_CLR_BIT(`FLT_M_VBAT_BIT)
	) u_ch3 (
		.i_cur(s_q.ch3_q),
		.i_det(i_ch3_det),
		.i_own_rd(1'b0),
		.i_third_rd(rd_third),
		.o_next(ch3_n)
	);

	channel_fault_latch #(
		.SHARED_CLR_BIT(`FLT_M_VBAT_BIT)
	) u_ch4 (
		.i_cur(s_q.ch4_q),
		.i_det(i_ch4_det),
		.i_own_rd(1'b0),
		.i_third_rd(rd_third),
		.o_next(ch4_n)
	);

	// Summary channel bits are live ORs; each of bits 7..4 drops only once its channel latch is empty, negative-leg battery bit included.
	assign ch1_any = |s_q.ch1_q;
	assign ch2_any = |s_q.ch2_q;
	assign ch3_any = |s_q.ch3_q;
	assign ch4_any = |s_q.ch4_q;

	always_comb begin
		summary = `LATCH_RESET;
		summary[`SUM_CH1_BIT] = ch1_any;
		summary[`SUM_CH2_BIT] = ch2_any;
		summary[`SUM_CH3_BIT] = ch3_any;
		summary[`SUM_CH4_BIT] = ch4_any;
		summary[`SUM_VBAT_LOW_BIT] = s_q.vbat_low_q;
	end

	// Unmapped offsets and the third global latch read back as zero from this bank.
	always_comb begin
		rd_mux = `LATCH_RESET;
		if (pg) begin
			unique case (i_addr)
				`SUMMARY_ADDR: begin
					rd_mux = summary;
				end
				`CH1_LATCH_ADDR: begin
					rd_mux = s_q.ch1_q;
				end
				`CH2_LATCH_ADDR: begin
					rd_mux = s_q.ch2_q;
				end
				`GLOBAL_LATCH_THIRD_ADDR: begin
					rd_mux = `LATCH_RESET;
				end
				default: begin
					// Offsets of channels 3 and 4 belong to a neighbouring bank.
					rd_mux = `LATCH_RESET;
				end
			endcase
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.ch1_q = ch1_n;
		s_d.ch2_q = ch2_n;
		s_d.ch3_q = ch3_n;
		s_d.ch4_q = ch4_n;
		// Set wins over the read clear, so a fault arriving during the read is still reported next time.
		s_d.vbat_low_q = (s_q.vbat_low_q && !rd_sum) || i_vbat_low_det;
		// Writes are accepted and discarded: every bit here is read-only.
		// The read value is captured before this cycle's clear takes effect.
		if (i_rd) begin
			s_d.rdata_q = rd_mux;
		end
	end

	// One register for the whole bank keeps reset and update in a single place.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Read data comes straight from its register, so the host never sees decode glitches.
	assign o_rdata = s_q.rdata_q;
endmodule

// File: testbench/fault_latch_chk_sva.sv
// Assertions on the fault latch read port.
`timescale 1ns/1ps
module fault_latch_chk (
	input wire logic i_clk, // Clock.
	input wire logic i_rst_b, // Reset.
	input wire logic [7:0] i_page, // Page.
	input wire logic [7:0] i_addr, // Address.
	input wire logic i_rd, // Read.
	input wire logic [7:0] i_ch1_det, // Ch1 faults.
	input wire logic i_vbat_low_det, // Low battery short.
	input wire logic [7:0] o_rdata // Read data.
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	wire logic p0 = i_rd && i_page == 8'h00;
	wire logic rs = p0 && i_addr == 8'h2D;
	wire logic r1 = p0 && i_addr == 8'h2E;
	wire logic rg = p0 && i_addr == 8'h36;
	wire logic d1 = |i_ch1_det;
	sequence det_rd1; d1 ##1 r1; endsequence
	sequence quiet_rd1; r1 && !d1 ##1 r1; endsequence
	a_rsv_zero: assert property (rs |=> o_rdata[3:2] == 2'b00 && !o_rdata[0]) else $error("rsv");
	a_idle_hold: assert property (!i_rd |=> $stable(o_rdata)) else $error("hold");
	a_ch1_set: assert property (det_rd1 |=> (o_rdata & $past(i_ch1_det, 2)) == $past(i_ch1_det, 2))
		else $error("set");
	a_rd_clear: assert property (quiet_rd1 |=> o_rdata[7:1] == 7'h00) else $error("clr");
	a_own_keep: assert property (r1 ##1 r1 |=> o_rdata[0] >= $past(o_rdata[0])) else $error("keep");
	a_third_clr: assert property (rg && !i_ch1_det[0] ##1 r1 |=> !o_rdata[0]) else $error("b0");
	a_sum_ch1: assert property (d1 ##1 rs |=> o_rdata[7]) else $error("s7");
	a_sum_vbat: assert property (i_vbat_low_det ##1 rs |=> o_rdata[1]) else $error("s1");
endmodule
bind input_fault_latch_status fault_latch_chk u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_page(i_page),
	.i_addr(i_addr), .i_rd(i_rd), .i_ch1_det(i_ch1_det), .i_vbat_low_det(i_vbat_low_det), .o_rdata(o_rdata));

// File: testbench/input_fault_latch_status_tb_top.sv
// Random self-checking bench for the fault latch bank.
`timescale 1ns/1ps
module input_fault_latch_status_tb_top;
	logic i_clk = 0, i_rst_b = 0, i_rd = 0, i_wr = 0, i_vbat_low_det = 0, vb = 0, skip = 0;
	logic [7:0] i_page = 0, i_addr = 0, i_wdata = 0, exp_q = 0, o_rdata;
	logic [7:0] det [4] = '{default: 0};
	logic [7:0] lat [4] = '{default: 0};
	logic [7:0] at [5] = '{8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h36};
	int num_errors = 0, checks = 0, seed = 89, cyc = 0;
	input_fault_latch_status DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_page(i_page), .i_addr(i_addr), .i_rd(i_rd),
		.i_wr(i_wr), .i_wdata(i_wdata), .i_ch1_det(det[0]), .i_ch2_det(det[1]), .i_ch3_det(det[2]),
		.i_ch4_det(det[3]), .i_vbat_low_det(i_vbat_low_det), .o_rdata(o_rdata));
	always #12.5 i_clk = ~i_clk;
	// Sparse detections keep the latches clearable often enough to see reads return zero.
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc > 5000) begin
			num_errors++;
			end_sim;
		end
		if (i_rst_b) begin
			i_rd <= ($random(seed) & 3) != 0;
			i_wr <= 1'($random(seed));
			i_wdata <= 8'($random(seed)) & 8'hF2;
			i_addr <= at[($random(seed) & 7) % 5];
			i_page <= {7'h00, ($random(seed) & 15) == 0};
			i_vbat_low_det <= ($random(seed) & 15) == 0;
			foreach (det[k]) det[k] <= ($random(seed) & 7) ? 8'h00 : 8'($random(seed));
		end
	end
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			lat = '{default: 0};
			vb = 0;
			exp_q = 0;
		end else begin
			if (i_rd) begin
				skip = i_page == 0 && i_addr == 8'h36;
				exp_q = i_page != 0 ? 8'h00 : i_addr == 8'h2D ? {|lat[0], |lat[1], |lat[2], |lat[3], 2'b00, vb, 1'b0}
					: i_addr == 8'h2E ? lat[0] : i_addr == 8'h2F ? lat[1] : 8'h00;
				if (i_page == 0 && i_addr == 8'h2D) vb = 0;
				if (i_page == 0 && i_addr == 8'h2E) lat[0][7:1] = 0;
				if (i_page == 0 && i_addr == 8'h2F) lat[1][7:1] = 0;
				if (skip) foreach (lat[k]) lat[k][0] = 0;
			end
			foreach (lat[k]) lat[k] |= det[k];
			vb |= i_vbat_low_det;
		end
	end
	always @(negedge i_clk) if (i_rst_b) begin
		checks++;
		if (o_rdata !== exp_q) begin
			num_errors++;
			$display("MISMATCH %0t rdata %h exp %h", $time, o_rdata, exp_q);
		end
	end
	task end_sim;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge i_clk);
		i_rst_b <= 1;
		repeat (2) @(posedge i_clk);
		$display("reset test done");
		repeat (3000) @(posedge i_clk);
		$display("random test done");
		i_rst_b <= 0;
		repeat (3) @(posedge i_clk);
		i_rst_b <= 1;
		repeat (200) @(posedge i_clk);
		$display("mid-run reset test done");
		end_sim;
	end
endmodule
